/* rtl/port_speed_negotiation.sv */
// downstream port speed negotiator: usb 2.0 detection, chirp handshake,
// superspeed termination check and training hand-off
// assumes synchronised levels are not guaranteed: line and phy flags are
// resynchronised here; analog termination and training live in the phy
`timescale 1ns/1ps
`default_nettype none

module port_speed_negotiation
    import port_speed_pkg::*;
#(
    parameter int RESET_LEN = RESET_LEN_DEF,
    parameter int CHIRP_WAIT = CHIRP_WAIT_DEF,
    parameter int CHIRP_PAIR = CHIRP_PAIR_DEF,
    parameter int TERM_WAIT = TERM_WAIT_DEF,
    parameter int TRAIN_WAIT = TRAIN_WAIT_DEF,
    parameter bit HS_CAPABLE = 1'b1,
    parameter bit SS_CAPABLE = 1'b1
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic dp_i,
    input wire logic dm_i,
    input wire logic term_found_i,
    input wire logic term_done_i,
    input wire logic link_u0_i,
    output logic [1:0] line_out_o,
    output logic line_oe_o,
    output logic hs_term_o,
    output logic term_req_o,
    output logic train_req_o,
    output speed_t speed_o,
    output logic speed_evt_o,
    output logic link_ready_o
);

    // ==========================================================
    // reset release
    // ==========================================================
    logic rst_meta;
    logic rst_n;

    // async assert, synchronous release through two flops
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ==========================================================
    // input synchronisers
    // ==========================================================
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] s3;
    logic [4:0] stable;

    // three stages; a change is taken once stage two and three agree
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= 5'h00;
            s2 <= 5'h00;
            s3 <= 5'h00;
            stable <= 5'h00;
        end else begin
            s1 <= {link_u0_i, term_done_i, term_found_i, dp_i, dm_i};
            s2 <= s1;
            s3 <= s2;
            for (int i = 0; i < 5; i++) begin
                if (s2[i] == s3[i]) begin
                    stable[i] <= s3[i];
                end
            end
        end
    end

    logic [1:0] line;
    assign line = stable[1:0];

    // previous line level, so the settle count can restart on any change
    logic [1:0] line_q;
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            line_q <= LINE_SE0;
        end else begin
            line_q <= line;
        end
    end

    // ==========================================================
    // negotiation state machine
    // ==========================================================
    typedef enum {
        ST_SS_DETECT,
        ST_SS_TRAIN,
        ST_SUPER,
        ST_WAIT_ATTACH,
        ST_BUS_RESET,
        ST_WAIT_CHIRP,
        ST_CHIRP_PAIRS,
        ST_HIGH,
        ST_FULL,
        ST_LOW
    } state_t;

    state_t state;
    state_t next_state;
    logic [CNT_W-1:0] tmr;
    logic [CNT_W-1:0] glitch;
    logic [3:0] pairs;

    // next-state decisions
    always_comb begin
        next_state = state;
        case (state)
            ST_SS_DETECT: begin
                if (stable[4]) begin
                    next_state = ST_SS_TRAIN;
                end else if (stable[3] || tmr >= CNT_W'(TERM_WAIT)) begin
                    next_state = stable[2] ? ST_SS_TRAIN : ST_WAIT_ATTACH;
                end
            end
            ST_SS_TRAIN: begin
                if (stable[4]) begin
                    next_state = ST_SUPER;
                end else if (tmr >= CNT_W'(TRAIN_WAIT)) begin
                    next_state = ST_WAIT_ATTACH;
                end
            end
            ST_SUPER: begin
                if (!stable[4]) begin
                    next_state = ST_WAIT_ATTACH;
                end
            end
            ST_WAIT_ATTACH: begin
                if (tmr >= CNT_W'(IDLE_SETTLE_CYC)) begin
                    if (line == LINE_FS_J) begin
                        next_state = HS_CAPABLE ? ST_BUS_RESET : ST_FULL;
                    end else if (line == LINE_FS_K) begin
                        next_state = ST_LOW;
                    end
                end
            end
            ST_BUS_RESET: begin
                if (tmr >= CNT_W'(RESET_LEN)) begin
                    next_state = ST_WAIT_CHIRP;
                end
            end
            ST_WAIT_CHIRP: begin
                if (glitch >= CNT_W'(CHIRP_MIN_CYC)) begin
                    next_state = ST_CHIRP_PAIRS;
                end else if (tmr >= CNT_W'(CHIRP_WAIT)) begin
                    next_state = ST_FULL;
                end
            end
            ST_CHIRP_PAIRS: begin
                if (pairs == 4'(CHIRP_PAIRS_DEF) && tmr == '0) begin
                    next_state = ST_HIGH;
                end
            end
            ST_FULL, ST_LOW: begin
                // detach shows as a settled SE0
                if (line == LINE_SE0 && tmr >= CNT_W'(IDLE_SETTLE_CYC)) begin
                    next_state = ST_WAIT_ATTACH;
                end
            end
            ST_HIGH: begin
                next_state = ST_HIGH;
            end
            default: next_state = ST_WAIT_ATTACH;
        endcase
    end

    // state register
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_SS_DETECT;
        end else if (!SS_CAPABLE && state == ST_SS_DETECT) begin
            state <= ST_WAIT_ATTACH;
        end else begin
            state <= next_state;
        end
    end

    // saturating step; a long wait must never wrap back below its limit
    logic [CNT_W-1:0] tmr_inc;
    assign tmr_inc = (tmr == {CNT_W{1'b1}}) ? tmr : tmr + 1'b1;

    // general timer; also counts settle time in idle states
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            tmr <= '0;
        end else if (next_state != state) begin
            tmr <= '0;
        end else if (state == ST_CHIRP_PAIRS) begin
            // one half of each pair lasts CHIRP_PAIR cycles
            tmr <= (tmr >= CNT_W'(CHIRP_PAIR - 1)) ? '0 : tmr + 1'b1;
        end else if (state == ST_WAIT_ATTACH) begin
            // any level change or SE0 restarts the settle count
            tmr <= (line != line_q || line == LINE_SE0) ? '0 : tmr_inc;
        end else if (state == ST_FULL || state == ST_LOW) begin
            // only an unbroken SE0 counts towards detach; a bounce starts over
            tmr <= (line == LINE_SE0) ? tmr_inc : '0;
        end else begin
            tmr <= tmr_inc;
        end
    end

    // chirp K must last; short chirps J and glitches reset the run
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            glitch <= '0;
        end else if (state == ST_WAIT_CHIRP && line == LINE_FS_K) begin
            glitch <= glitch + 1'b1;
        end else begin
            glitch <= '0;
        end
    end

    logic half;
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            pairs <= 4'h0;
            half <= 1'b0;
        end else if (state != ST_CHIRP_PAIRS) begin
            pairs <= 4'h0;
            half <= 1'b0;
        end else if (tmr == CNT_W'(CHIRP_PAIR - 1)) begin
            half <= ~half;
            if (half && pairs != 4'(CHIRP_PAIRS_DEF)) begin
                pairs <= pairs + 4'h1;
            end
        end
    end

    // ==========================================================
    // line drive and superspeed requests
    // ==========================================================
    // reset as SE0, then alternating K and J
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            line_oe_o <= 1'b0;
            line_out_o <= LINE_SE0;
            hs_term_o <= 1'b0;
        end else begin
            line_oe_o <= (next_state == ST_BUS_RESET) || (next_state == ST_CHIRP_PAIRS);
            line_out_o <= (next_state == ST_CHIRP_PAIRS && state == ST_CHIRP_PAIRS)
                          ? (half ? LINE_FS_J : LINE_FS_K)
                          : (next_state == ST_CHIRP_PAIRS ? LINE_FS_K : LINE_SE0);
            // terminations on from the chirp pairs onwards and in high speed
            hs_term_o <= (next_state == ST_CHIRP_PAIRS) || (next_state == ST_HIGH);
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            term_req_o <= 1'b0;
            train_req_o <= 1'b0;
            link_ready_o <= 1'b0;
        end else begin
            term_req_o <= (next_state == ST_SS_DETECT) && SS_CAPABLE;
            train_req_o <= (next_state == ST_SS_TRAIN);
            link_ready_o <= (next_state == ST_SUPER);
        end
    end

    // ==========================================================
    // speed report
    // ==========================================================
    speed_t next_speed;

    always_comb begin
        case (next_state)
            ST_LOW: next_speed = SPEED_LOW;
            ST_FULL, ST_BUS_RESET, ST_WAIT_CHIRP, ST_CHIRP_PAIRS: next_speed = SPEED_FULL;
            ST_HIGH: next_speed = SPEED_HIGH;
            ST_SUPER: next_speed = SPEED_SUPER;
            default: next_speed = SPEED_NONE;
        endcase
    end

    // one pulse per change, fallback included
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            speed_o <= SPEED_NONE;
            speed_evt_o <= 1'b0;
        end else begin
            speed_o <= next_speed;
            speed_evt_o <= (next_speed != speed_o)
                           || (state == ST_SS_DETECT && next_state == ST_WAIT_ATTACH)
                           || (state == ST_SS_TRAIN && next_state == ST_WAIT_ATTACH);
        end
    end

endmodule // port_speed_negotiation

`default_nettype wire

/* rtl/port_speed_pkg.sv */
// constants and carrier types for the downstream port speed negotiator
// assumes a single 100 MHz system clock; line levels arrive from a transceiver
// What this block does
// - idle line with positive data high means a full-speed peripheral
// - idle line with negative data high means a low-speed peripheral
// - port serves low and full speed, high speed when high-speed capable, superspeed when superspeed capable
// - report negotiated rate: low, full, high speed, or superspeed
// - high-speed port seeing full speed drives reset, then watches for chirp K
// - no chirp K after reset means stay at full speed
// - on chirp K answer with alternating chirp K and chirp J pairs
// - short spurious chirp K during handshake is ignored
// - transmitter checks far receiver termination before superspeed traffic
// - no termination found means fall back to the USB 2.0 channel
// - termination found means link training, then U0 before data
package port_speed_pkg;

    // clock period in ns
    localparam int CLK_PERIOD_NS = 10;
    // idle debounce before a speed is taken from the line
    localparam int IDLE_SETTLE_NS = 2500;
    localparam int IDLE_SETTLE_CYC = (IDLE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // a chirp K shorter than this is a glitch
    localparam int CHIRP_MIN_NS = 2500;
    localparam int CHIRP_MIN_CYC = (CHIRP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // default bounds, overridable at the top except CHIRP_PAIRS_DEF and CNT_W
    localparam int RESET_LEN_DEF = 1000000;
    localparam int CHIRP_WAIT_DEF = 700000;
    localparam int CHIRP_PAIR_DEF = 5000;
    localparam int CHIRP_PAIRS_DEF = 3;
    localparam int TERM_WAIT_DEF = 10000;
    localparam int TRAIN_WAIT_DEF = 1200000;
    localparam int CNT_W = 24;

    // line state codes, D+ in bit 1, D- in bit 0
    localparam logic [1:0] LINE_SE0 = 2'h0;
    localparam logic [1:0] LINE_FS_K = 2'h1;
    localparam logic [1:0] LINE_FS_J = 2'h2;

    // negotiated speed codes
    typedef enum logic [2:0] {
        SPEED_NONE,
        SPEED_LOW,
        SPEED_FULL,
        SPEED_HIGH,
        SPEED_SUPER
    } speed_t;

    // what the port drives onto the data pair
    typedef struct packed {
        logic drive;
        logic [1:0] level;
    } line_drive_t;

    // superspeed channel handshake with the link layer
    typedef struct packed {
        logic term_req;
        logic train_req;
    } ss_ctrl_t;

endpackage

/* verification/port_speed_negotiation_bench.sv */
// self-checking bench: negotiator against the peripheral model
// assumes shortened counts; expectations follow the parameters set here
`timescale 1ns/1ps
`default_nettype none
module port_speed_negotiation_bench
    import port_speed_pkg::*;
();
    // ==========
    // wiring
    localparam int RL = 200;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic dp, dm, tf, td, u0, oe, hs_term, t_req, tr_req, evt, ready;
    logic [1:0] mode = 2'h0;
    logic ss = 1'b0;
    logic [1:0] lvl;
    speed_t speed;
    int k_len;
    int err_total = 0;
    int checks_done = 0;
    int cyc = 0;
    port_speed_negotiation #(.RESET_LEN(RL), .CHIRP_WAIT(2000), .CHIRP_PAIR(20),
        .TERM_WAIT(50), .TRAIN_WAIT(500)) u_dut (.clk_sys_i, .resetn_i, .dp_i(dp),
        .dm_i(dm), .term_found_i(tf), .term_done_i(td), .link_u0_i(u0), .line_out_o(lvl),
        .line_oe_o(oe), .hs_term_o(hs_term), .term_req_o(t_req), .train_req_o(tr_req),
        .speed_o(speed), .speed_evt_o(evt), .link_ready_o(ready));
    usb_peripheral_model #(.RESET_LEN(RL)) u_peer (.clk_i(clk_sys_i), .mode_i(mode),
        .ss_i(ss), .line_out_i(lvl), .line_oe_i(oe), .term_req_i(t_req),
        .train_req_i(tr_req), .dp_o(dp), .dm_o(dm), .term_found_o(tf), .term_done_o(td),
        .link_u0_o(u0), .k_len_o(k_len));
    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // hang guard, far above the few thousand cycles needed
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            report_and_stop();
        end
    end
    // ==========
    // helpers
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic wait_speed(input speed_t s, input int lim);
        for (int i = 0; i < lim && speed !== s; i++) @(negedge clk_sys_i);
    endtask
    // reset held 12 cycles while the peripheral is swapped
    task automatic restart(input logic [1:0] m, input logic s);
        resetn_i = 1'b0;
        mode = m;
        ss = s;
        repeat (12) @(negedge clk_sys_i);
        resetn_i = 1'b1;
    endtask
    task automatic report_and_stop();
        if (err_total == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ==========
    // scenarios
    // superspeed bring-up
    task automatic t_super();
        restart(2'h0, 1'h1);
        wait_speed(SPEED_SUPER, 100);
        chk("speed_ss", speed, SPEED_SUPER);
        chk("evt_ss", evt, 8'h1);
        chk("link_ready", ready, 8'h1);
        // U0 must hold with both phy requests dropped
        repeat (20) @(negedge clk_sys_i);
        chk("ss_hold", {ready, t_req, tr_req}, 8'h4);
    endtask
    // full speed, no chirp, then detach
    task automatic t_full();
        restart(2'h1, 1'h0);
        wait_speed(SPEED_FULL, 400);
        chk("speed_fs", speed, SPEED_FULL);
        chk("bus_reset", {oe, lvl}, {1'h1, LINE_SE0});
        for (int i = 0; i < 3000 && oe; i++) @(negedge clk_sys_i);
        // let the chirp wait run out so the port is really back at full speed
        repeat (2100) @(negedge clk_sys_i);
        chk("fs_kept", {speed, oe, hs_term}, {SPEED_FULL, 2'h0});
        mode = 2'h0;
        wait_speed(SPEED_NONE, 400);
        chk("detach", speed, SPEED_NONE);
    endtask
    task automatic t_low();
        restart(2'h2, 1'h0);
        wait_speed(SPEED_LOW, 400);
        chk("speed_ls", speed, SPEED_LOW);
        chk("evt_ls", evt, 8'h1);
        chk("ls_no_hs_term", hs_term, 8'h0);
    endtask
    // glitch ignored, real chirp answered, high speed
    task automatic t_high();
        restart(2'h3, 1'h0);
        for (int i = 0; i < 3000 && !(oe && lvl == LINE_FS_K); i++) @(negedge clk_sys_i);
        chk("chirp_answer_late", k_len >= 250, 8'h1);
        wait_speed(SPEED_HIGH, 500);
        chk("speed_hs", speed, SPEED_HIGH);
        chk("evt_hs", evt, 8'h1);
        chk("hs_term", hs_term, 8'h1);
    endtask
    initial begin
        @(negedge clk_sys_i);
        t_super();
        t_full();
        t_low();
        t_high();
        report_and_stop();
    end
endmodule // port_speed_negotiation_bench
`default_nettype wire

/* verification/port_speed_negotiation_sva.sv */
// checker for the port speed negotiator, watching its top ports only
// assumes it is bound onto every instance of the negotiator
`timescale 1ns/1ps
`default_nettype none
module port_speed_negotiation_sva
    import port_speed_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic dp_i,
    input wire logic dm_i,
    input wire logic term_found_i,
    input wire logic term_done_i,
    input wire logic link_u0_i,
    input wire logic [1:0] line_out_o,
    input wire logic line_oe_o,
    input wire logic hs_term_o,
    input wire logic term_req_o,
    input wire logic train_req_o,
    input wire speed_t speed_o,
    input wire logic speed_evt_o,
    input wire logic link_ready_o
);
    // ==========
    // relations; the async reset masks them all
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);
    chk_evt_pulse: assert property (speed_evt_o |=> !speed_evt_o)
        else $error("speed event longer than one cycle");
    chk_evt_on_change: assert property ($changed(speed_o) |-> ##[0:1] speed_evt_o)
        else $error("speed changed without event");
    chk_fallback_evt: assert property ($rose(term_done_i) && !term_found_i |-> ##[1:12] speed_evt_o)
        else $error("no event on fallback");
    chk_train_needs_term: assert property ($rose(train_req_o) |-> term_found_i)
        else $error("training without termination");
    chk_u0_ready: assert property ($rose(link_u0_i) && speed_o == SPEED_NONE |-> ##[1:12] link_ready_o)
        else $error("U0 not reported");
    chk_ready_super: assert property (link_ready_o |-> speed_o == SPEED_SUPER)
        else $error("ready outside superspeed");
    chk_reset_se0: assert property ($rose(line_oe_o) && $past(speed_o) == SPEED_NONE |-> line_out_o == LINE_SE0 && speed_o == SPEED_FULL)
        else $error("bus reset not SE0 at full speed");
    chk_chirp_k_hold: assert property ($rose(line_oe_o && line_out_o == LINE_FS_K) |-> (line_oe_o && line_out_o == LINE_FS_K)[*8])
        else $error("chirp K too short");
    cov_high: cover property (speed_o == SPEED_HIGH);
    cov_low: cover property (speed_o == SPEED_LOW);
    cov_super: cover property (link_ready_o);
endmodule // port_speed_negotiation_sva
bind port_speed_negotiation port_speed_negotiation_sva u_sva (.clk_sys_i, .resetn_i, .dp_i, .dm_i,
    .term_found_i, .term_done_i, .link_u0_i, .line_out_o, .line_oe_o, .hs_term_o, .term_req_o,
    .train_req_o, .speed_o, .speed_evt_o, .link_ready_o);
`default_nettype wire

/* verification/usb_peripheral_model.sv */
// attached peripheral: none, full, low or high speed, plus a superspeed receiver
// assumes port outputs are seen directly; state moves on the falling edge
`timescale 1ns/1ps
`default_nettype none
module usb_peripheral_model
    import port_speed_pkg::*;
#(
    parameter int RESET_LEN = 200
) (
    input wire logic clk_i,
    input wire logic [1:0] mode_i,
    input wire logic ss_i,
    input wire logic [1:0] line_out_i,
    input wire logic line_oe_i,
    input wire logic term_req_i,
    input wire logic train_req_i,
    output logic dp_o,
    output logic dm_o,
    output logic term_found_o = 1'b0,
    output logic term_done_o = 1'b0,
    output logic link_u0_o = 1'b0,
    output int k_len_o = 0
);
    // ==========
    // handshake state
    int se0_cnt = 0;
    int t = 0;
    int step = 0;
    int turns = 0;
    int tc = 0;
    logic hs_on = 1'b0;
    logic [1:0] last = 2'h0;
    logic drive_k;
    logic [1:0] idle;
    // pull-up shows full speed until the device goes high speed
    assign idle = (mode_i == 2'h2) ? 2'h1 : (mode_i == 2'h0 || hs_on) ? 2'h0 : 2'h2;
    assign drive_k = (step == 1) || (step == 3);
    // device chirp overrides the port drive, never SE1
    assign {dp_o, dm_o} = drive_k ? LINE_FS_K : line_oe_i ? line_out_i : idle;
    // termination check answer, then U0 after training
    always @(negedge clk_i) begin
        term_found_o <= ss_i;
        term_done_o <= term_req_i;
        tc <= train_req_i ? tc + 1 : 0;
        link_u0_o <= ss_i && (link_u0_o || tc >= 20); // trained link stays in U0
        k_len_o <= drive_k ? k_len_o + 1 : 0;
    end
    // short K glitch, real chirp, pull-up dropped after two pairs
    always @(negedge clk_i) begin
        t <= t + 1;
        last <= line_out_i;
        if (line_oe_i && line_out_i == LINE_SE0)
            se0_cnt <= se0_cnt + 1;
        if (mode_i != 2'h3) begin
            step <= 0;
            se0_cnt <= 0;
            turns <= 0;
            hs_on <= 1'b0;
        end else if (step == 0 && se0_cnt >= RESET_LEN - 10) begin
            step <= 1;
            t <= 0;
        end else if ((step == 1 && t == 99) || (step == 2 && t == 29)) begin
            step <= step + 1;
            t <= 0;
        end else if (step == 3 && line_oe_i && line_out_i == LINE_FS_K)
            step <= 4;
        else if (step == 4 && line_oe_i && line_out_i == LINE_FS_J && last != LINE_FS_J)
            turns <= turns + 1;
        if (turns == 2)
            hs_on <= 1'b1;
    end
endmodule // usb_peripheral_model
`default_nettype wire
